// ### src/irq_input_pkg.sv
/*
 * Constants shared by the interrupt input stage: register addresses,
 * reset values and the number of request positions.
 * Assumes a 32-bit register address space with word-aligned registers.
 */
package irq_input_pkg;

	// Number of request positions handled by the block.
	localparam int REQ_COUNT = 32;

	// Width of the register bus address and data.
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;

	// Register byte addresses.
	localparam logic [ADDR_W-1:0] NORMAL_STATUS_ADDR = 32'hfffff000;
	localparam logic [ADDR_W-1:0] FAST_STATUS_ADDR = 32'hfffff004;
	localparam logic [ADDR_W-1:0] RAW_STATUS_ADDR = 32'hfffff008;
	localparam logic [ADDR_W-1:0] CLASSIFICATION_ADDR = 32'hfffff00c;
	localparam logic [ADDR_W-1:0] ENABLE_SET_ADDR = 32'hfffff010;
	localparam logic [ADDR_W-1:0] ENABLE_CLEAR_ADDR = 32'hfffff014;
	localparam logic [ADDR_W-1:0] FORCED_SET_ADDR = 32'hfffff018;
	localparam logic [ADDR_W-1:0] FORCED_CLEAR_ADDR = 32'hfffff01c;
	localparam logic [ADDR_W-1:0] EVENT_STATUS_ADDR = 32'hfffff040;
	localparam logic [ADDR_W-1:0] EVENT_MASK_ADDR = 32'hfffff044;

	// Reset values of the stored registers.
	localparam logic [DATA_W-1:0] ENABLE_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] FORCED_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] CLASSIFICATION_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] EVENT_MASK_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;

endpackage : irq_input_pkg

// ### src/request_router.sv
/*
 * Combines request lines with forced requests, gates them by the enable
 * mask and splits them into fast and normal categories, all registered.
 * Assumes request lines are synchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module request_router #(
	parameter int N = 32
) (
	input wire logic core_clk, // System clock.
	input wire logic arst_n, // Asynchronous reset, active low.
	input wire logic [N-1:0] request_lines, // Peripheral request lines.
	input wire logic [N-1:0] forced_request, // Software-forced requests.
	input wire logic [N-1:0] enable_mask, // Enable bit per position.
	input wire logic [N-1:0] classification, // 1 selects the fast category.
	output logic [N-1:0] raw_status, // Request or forced, unmasked.
	output logic [N-1:0] enabled_request, // Raw and enabled.
	output logic [N-1:0] fast_status, // Enabled requests classed fast.
	output logic [N-1:0] normal_status, // Enabled requests classed normal.
	output logic fast_interrupt, // Any fast request active.
	output logic normal_interrupt // Any normal request active.
);

	logic [N-1:0] raw_next;
	logic [N-1:0] enabled_next;
	logic [N-1:0] fast_next;
	logic [N-1:0] normal_next;

	// Raw state is formed before enabling, then split by class.
	always_comb begin
		raw_next = request_lines | forced_request;
		enabled_next = raw_next & enable_mask;
		fast_next = enabled_next & classification;
		normal_next = enabled_next & ~classification;
	end

	// Registers the views so that every output comes from a flip-flop.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			raw_status <= '0;
			enabled_request <= '0;
			fast_status <= '0;
			normal_status <= '0;
			fast_interrupt <= 1'b0;
			normal_interrupt <= 1'b0;
		end else begin
			raw_status <= raw_next;
			enabled_request <= enabled_next;
			fast_status <= fast_next;
			normal_status <= normal_next;
			fast_interrupt <= |fast_next;
			normal_interrupt <= |normal_next;
		end
	end

endmodule : request_router

`default_nettype wire

// ### src/event_capture.sv
/*
 * Sticky per-position event flags set on a rising raw request, cleared
 * by writing ones, masked onto one level interrupt output.
 * Assumes raw status is already registered in the core_clk domain.
 */
`timescale 1ns/1ps
`default_nettype none

module event_capture #(
	parameter int N = 32
) (
	input wire logic core_clk, // System clock.
	input wire logic arst_n, // Asynchronous reset, active low.
	input wire logic [N-1:0] raw_status, // Registered raw request view.
	input wire logic [N-1:0] clear_bits, // One-cycle write-ones-to-clear.
	input wire logic [N-1:0] event_mask, // 1 lets a flag reach the output.
	output logic [N-1:0] event_status, // Sticky rising-edge flags.
	output logic event_irq // High while an unmasked flag is set.
);

	logic [N-1:0] prev_raw_reg;
	logic [N-1:0] status_next;
	logic irq_next;

	// Per position: a new rising edge wins over a clear in the same cycle.
	always_comb begin
		for (int i = 0; i < N; i++) begin
			status_next[i] = (raw_status[i] & ~prev_raw_reg[i]) |
				(event_status[i] & ~clear_bits[i]);
		end
		irq_next = |(status_next & event_mask);
	end

	// Holds the flags, the previous raw view and the interrupt level.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_raw_reg <= '0;
			event_status <= '0;
			event_irq <= 1'b0;
		end else begin
			prev_raw_reg <= raw_status;
			event_status <= status_next;
			event_irq <= irq_next;
		end
	end

endmodule : event_capture

`default_nettype wire

// ### src/irq_input_stage.sv
/*
 * Input stage of a vectored interrupt controller: raw request view,
 * forced requests with write-ones-to-clear, enable mask with separate
 * set and clear ports, classification, and a rising-edge event monitor.
 * Assumes a single clock, request lines synchronous to it, and a bus
 * master that issues one-cycle strokes and takes read data a cycle later.
 */
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Writing 1 to a forced-clear bit clears that forced request.
// - Writing 0 to a forced-clear bit leaves that forced request unchanged.
// - Several forced bits clear in one write, no read-modify-write.
// - Raw status is read-only: lines OR forced, ignoring enable and class.
// - Only enabled requests reach fast or normal outputs; 32 enable bits.
// - Enable register reads 1 for each currently enabled position.
// - Enable writes set ones and ignore zeros.
// - Enable clear register is write-only, used without reading enables.
// - Writing 1 to an enable-clear bit disables that position.
// - Writing 0 to an enable-clear bit leaves that enable unchanged.
// - Raw state is request line OR forced bit, before other logic.
// - Enabled request goes fast when class bit is 1, else normal.
// - Normal status shows asserted, enabled, normal-class positions only.
module irq_input_stage
	import irq_input_pkg::*;
#(
	parameter int N = irq_input_pkg::REQ_COUNT
) (
	input wire logic core_clk, // System clock, 100 MHz.
	input wire logic arst_n, // Asynchronous reset, active low.
	input wire logic [N-1:0] request_lines, // Peripheral request lines.
	input wire logic [irq_input_pkg::ADDR_W-1:0] reg_addr, // Register byte address.
	input wire logic [irq_input_pkg::DATA_W-1:0] reg_wdata, // Write data.
	input wire logic reg_write, // One-cycle write strobe.
	input wire logic reg_read, // One-cycle read strobe.
	output logic [irq_input_pkg::DATA_W-1:0] reg_rdata, // Read data, cycle after strobe.
	output logic [N-1:0] forced_request, // Forced-request vector.
	output logic [N-1:0] enabled_request, // Enabled-request vector.
	output logic [N-1:0] request_classification, // Class per position.
	output logic fast_interrupt, // Fast interrupt level.
	output logic normal_interrupt, // Normal interrupt level.
	output logic event_irq // Event monitor interrupt level.
);

	import irq_input_pkg::*;

	// Stored control state and its next values.
	logic [N-1:0] enable_reg;
	logic [N-1:0] enable_next;
	logic [N-1:0] forced_request_reg;
	logic [N-1:0] forced_request_next;
	logic [N-1:0] classification_reg;
	logic [N-1:0] classification_next;
	logic [N-1:0] event_mask_reg;
	logic [N-1:0] event_mask_next;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;

	// Write decodes.
	logic wr_enable_set;
	logic wr_enable_clear;
	logic wr_forced_set;
	logic wr_forced_clear;
	logic wr_classification;
	logic wr_event_status;
	logic wr_event_mask;
	logic [N-1:0] wdata_bits;
	logic [N-1:0] event_clear_bits;

	// Views from the router and event monitor.
	logic [N-1:0] raw_status;
	logic [N-1:0] fast_status;
	logic [N-1:0] normal_status;
	logic [N-1:0] event_status;

	// Address decode for each writable register; read-only ones have none.
	always_comb begin
		wdata_bits = reg_wdata[N-1:0];
		wr_enable_set = reg_write && (reg_addr == ENABLE_SET_ADDR);
		wr_enable_clear = reg_write && (reg_addr == ENABLE_CLEAR_ADDR);
		wr_forced_set = reg_write && (reg_addr == FORCED_SET_ADDR);
		wr_forced_clear = reg_write && (reg_addr == FORCED_CLEAR_ADDR);
		wr_classification = reg_write && (reg_addr == CLASSIFICATION_ADDR);
		wr_event_status = reg_write && (reg_addr == EVENT_STATUS_ADDR);
		wr_event_mask = reg_write && (reg_addr == EVENT_MASK_ADDR);
		event_clear_bits = wr_event_status ? wdata_bits : '0;
	end

	// Next values of the stored control registers.
	always_comb begin
		enable_next = enable_reg;
		forced_request_next = forced_request_reg;
		classification_next = classification_reg;
		event_mask_next = event_mask_reg;
		if (wr_enable_set) begin
			enable_next = enable_reg | wdata_bits;
		end
		if (wr_enable_clear) begin
			enable_next = enable_reg & ~wdata_bits;
		end
		if (wr_forced_set) begin
			forced_request_next = forced_request_reg | wdata_bits;
		end
		if (wr_forced_clear) begin
			forced_request_next = forced_request_reg & ~wdata_bits;
		end
		if (wr_classification) begin
			classification_next = wdata_bits;
		end
		if (wr_event_mask) begin
			event_mask_next = wdata_bits;
		end
	end

	// Read multiplexer; unmapped and write-only addresses read as zero.
	always_comb begin
		rdata_next = READ_ZERO;
		if (reg_read) begin
			unique case (reg_addr)
				NORMAL_STATUS_ADDR: rdata_next[N-1:0] = normal_status;
				FAST_STATUS_ADDR: rdata_next[N-1:0] = fast_status;
				RAW_STATUS_ADDR: rdata_next[N-1:0] = raw_status;
				CLASSIFICATION_ADDR: rdata_next[N-1:0] = classification_reg;
				ENABLE_SET_ADDR: rdata_next[N-1:0] = enable_reg;
				ENABLE_CLEAR_ADDR: rdata_next = READ_ZERO;
				FORCED_SET_ADDR: rdata_next[N-1:0] = forced_request_reg;
				FORCED_CLEAR_ADDR: rdata_next = READ_ZERO;
				EVENT_STATUS_ADDR: rdata_next[N-1:0] = event_status;
				EVENT_MASK_ADDR: rdata_next[N-1:0] = event_mask_reg;
				default: rdata_next = READ_ZERO;
			endcase
		end
	end

	// Registers all control state and the read data.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			enable_reg <= ENABLE_RESET[N-1:0];
			forced_request_reg <= FORCED_RESET[N-1:0];
			classification_reg <= CLASSIFICATION_RESET[N-1:0];
			event_mask_reg <= EVENT_MASK_RESET[N-1:0];
			rdata_reg <= READ_ZERO;
		end else begin
			enable_reg <= enable_next;
			forced_request_reg <= forced_request_next;
			classification_reg <= classification_next;
			event_mask_reg <= event_mask_next;
			rdata_reg <= rdata_next;
		end
	end

	// Combines, gates and classifies the requests.
	request_router #(
		.N(N)
	) router (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.request_lines(request_lines),
		.forced_request(forced_request_reg),
		.enable_mask(enable_reg),
		.classification(classification_reg),
		.raw_status(raw_status),
		.enabled_request(enabled_request),
		.fast_status(fast_status),
		.normal_status(normal_status),
		.fast_interrupt(fast_interrupt),
		.normal_interrupt(normal_interrupt)
	);

	// Catches rising raw requests as sticky, maskable events.
	event_capture #(
		.N(N)
	) events (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.raw_status(raw_status),
		.clear_bits(event_clear_bits),
		.event_mask(event_mask_reg),
		.event_status(event_status),
		.event_irq(event_irq)
	);

	// Drives the register-backed outputs.
	assign reg_rdata = rdata_reg;
	assign forced_request = forced_request_reg;
	assign request_classification = classification_reg;

endmodule : irq_input_stage

`default_nettype wire

// ### bench/periph_requests.sv
/* Model of the peripherals that drive the request lines.
   Assumes the bench sets the wanted pattern by non-blocking assignment. */
`timescale 1ns/1ps
`default_nettype none
module periph_requests #(parameter int N = 32) (
	input wire logic core_clk, // Clock.
	input wire logic arst_n, // Reset, active low.
	input wire logic [N-1:0] want, // Pattern the peripherals raise.
	output logic [N-1:0] request_lines // Level requests, clock synchronous.
);
	// Each peripheral registers its request, so lines only move after an edge.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) request_lines <= '0;
		else request_lines <= want;
	end
endmodule : periph_requests
`default_nettype wire

// ### bench/irq_input_stage_chk.sv
/* Port assertions for the interrupt input stage.
   Assumes one clock and one-cycle register strobes. */
`timescale 1ns/1ps
`default_nettype none
module irq_input_stage_chk
	import irq_input_pkg::*;
#(parameter int N = 32) (
	input wire logic core_clk, // Clock.
	input wire logic arst_n, // Reset, active low.
	input wire logic [N-1:0] request_lines, // Request lines.
	input wire logic [irq_input_pkg::ADDR_W-1:0] reg_addr, // Address.
	input wire logic [irq_input_pkg::DATA_W-1:0] reg_wdata, // Write data.
	input wire logic reg_write, // Write strobe.
	input wire logic reg_read, // Read strobe.
	input wire logic [irq_input_pkg::DATA_W-1:0] reg_rdata, // Read data.
	input wire logic [N-1:0] forced_request, // Forced vector.
	input wire logic [N-1:0] enabled_request, // Enabled vector.
	input wire logic [N-1:0] request_classification, // Class vector.
	input wire logic fast_interrupt, // Fast level.
	input wire logic normal_interrupt // Normal level.
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// Register strokes that the properties start from.
	sequence s_fclr; reg_write && reg_addr == FORCED_CLEAR_ADDR; endsequence
	sequence s_eclr; reg_write && reg_addr == ENABLE_CLEAR_ADDR; endsequence
	sequence s_wo_rd;
		reg_read && (reg_addr == FORCED_CLEAR_ADDR || reg_addr == ENABLE_CLEAR_ADDR);
	endsequence
	property p_fclr_one; s_fclr |=> (forced_request & $past(reg_wdata)) == '0; endproperty
	property p_fclr_zero;
		s_fclr |=> (forced_request & ~$past(reg_wdata)) == ($past(forced_request) & ~$past(reg_wdata));
	endproperty
	property p_fset;
		reg_write && reg_addr == FORCED_SET_ADDR |=> (forced_request & $past(reg_wdata)) == $past(reg_wdata);
	endproperty
	property p_raw;
		reg_read && reg_addr == RAW_STATUS_ADDR |=>
			reg_rdata == ($past(request_lines, 2) | $past(forced_request, 2));
	endproperty
	property p_eclr; s_eclr |-> ##2 (enabled_request & $past(reg_wdata, 2)) == '0; endproperty
	property p_wo_rd; s_wo_rd |=> reg_rdata == '0 && $stable(forced_request); endproperty
	property p_idle_rd; !reg_read |=> reg_rdata == '0; endproperty
	property p_normal;
		normal_interrupt == |(enabled_request & ~$past(request_classification));
	endproperty
	property p_fast; fast_interrupt == |(enabled_request & $past(request_classification)); endproperty
	a_fclr_one: assert property (p_fclr_one) else $error("forced bit kept after clear");
	a_fclr_zero: assert property (p_fclr_zero) else $error("forced bit lost");
	a_fset: assert property (p_fset) else $error("forced bit not set");
	a_raw: assert property (p_raw) else $error("raw read wrong");
	a_eclr: assert property (p_eclr) else $error("enable survived clear");
	a_wo_rd: assert property (p_wo_rd) else $error("clear port read wrong");
	a_idle_rd: assert property (p_idle_rd) else $error("read data without read");
	a_normal: assert property (p_normal) else $error("normal level wrong");
	a_fast: assert property (p_fast) else $error("fast level wrong");
endmodule : irq_input_stage_chk
bind irq_input_stage irq_input_stage_chk #(.N(N)) i_irq_input_stage_chk (.core_clk(core_clk),
	.arst_n(arst_n), .request_lines(request_lines), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.forced_request(forced_request), .enabled_request(enabled_request),
	.request_classification(request_classification), .fast_interrupt(fast_interrupt),
	.normal_interrupt(normal_interrupt));
`default_nettype wire

// ### bench/test_irq_input_stage.sv
/* Self-checking bench for the interrupt input stage.
   Assumes the package, the request model and the checker compile first. */
`timescale 1ns/1ps
`default_nettype none
module test_irq_input_stage;
	import irq_input_pkg::*;
	logic core_clk = 1'h0;
	logic arst_n = 1'h0;
	logic reg_write = 1'h0;
	logic reg_read = 1'h0;
	logic [31:0] want = '0, reg_addr = '0, reg_wdata = '0, reg_rdata, lines, forced, enabled, cls;
	logic fast_irq, normal_irq, ev_irq;
	int errors = 0;
	int compares = 0;
	// Design and the peripheral model in front of it.
	periph_requests i_periph_requests (.core_clk(core_clk), .arst_n(arst_n), .want(want),
		.request_lines(lines));
	irq_input_stage i_irq_input_stage (.core_clk(core_clk), .arst_n(arst_n),
		.request_lines(lines), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.forced_request(forced), .enabled_request(enabled), .request_classification(cls),
		.fast_interrupt(fast_irq), .normal_interrupt(normal_irq), .event_irq(ev_irq));
	// Free-running 100 MHz clock.
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	// Compares one value and counts the outcome.
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// One-cycle register write.
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_write <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_write <= 1'h0;
	endtask : wr
	// One-cycle register read, data judged in the following cycle.
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_read <= 1'h1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_read <= 1'h0;
		#1 chk("read data", reg_rdata, exp);
	endtask : rd
	// Every register, both clear ports and an unmapped word read zero after reset.
	task automatic t_reset();
		logic [31:0] map [11] = '{ENABLE_SET_ADDR, FORCED_SET_ADDR, CLASSIFICATION_ADDR,
			RAW_STATUS_ADDR, NORMAL_STATUS_ADDR, FAST_STATUS_ADDR, EVENT_STATUS_ADDR,
			EVENT_MASK_ADDR, ENABLE_CLEAR_ADDR, FORCED_CLEAR_ADDR, 32'hfffff020};
		foreach (map[i]) rd(map[i], READ_ZERO);
	endtask : t_reset
	// Enable set ignores zeros, enable clear removes only the ones written.
	task automatic t_enable();
		wr(ENABLE_SET_ADDR, 32'h00000005);
		wr(ENABLE_SET_ADDR, 32'h800000a0);
		rd(ENABLE_SET_ADDR, 32'h800000a5);
		wr(ENABLE_CLEAR_ADDR, 32'h80000081);
		rd(ENABLE_SET_ADDR, 32'h00000024);
		rd(ENABLE_CLEAR_ADDR, 32'h00000000);
	endtask : t_enable
	// All positions forced, then several cleared in one write.
	task automatic t_forced();
		wr(FORCED_SET_ADDR, 32'hffffffff);
		rd(FORCED_SET_ADDR, 32'hffffffff);
		wr(FORCED_CLEAR_ADDR, 32'h80000003);
		rd(FORCED_SET_ADDR, 32'h7ffffffc);
		rd(FORCED_CLEAR_ADDR, 32'h00000000);
		rd(FORCED_SET_ADDR, 32'h7ffffffc);
		chk("forced vector", forced, 32'h7ffffffc);
	endtask : t_forced
	// Raw view is lines OR forced, whatever the enables are.
	task automatic t_raw();
		wr(FORCED_CLEAR_ADDR, 32'hffffffff);
		wr(FORCED_SET_ADDR, 32'h00000110);
		want <= 32'h00000100;
		repeat (3) @(posedge core_clk);
		rd(RAW_STATUS_ADDR, 32'h00000110);
		wr(FORCED_CLEAR_ADDR, 32'h00000110);
		rd(RAW_STATUS_ADDR, 32'h00000100);
	endtask : t_raw
	// Enabled requests split by class; a disabled one drops out.
	task automatic t_route();
		wr(ENABLE_CLEAR_ADDR, 32'hffffffff);
		wr(ENABLE_SET_ADDR, 32'h00000003);
		wr(CLASSIFICATION_ADDR, 32'h00000002);
		want <= 32'h00000103;
		repeat (4) @(posedge core_clk);
		#1 chk("fast", 32'(fast_irq), 32'h1);
		chk("normal", 32'(normal_irq), 32'h1);
		chk("class vector", cls, 32'h00000002);
		rd(CLASSIFICATION_ADDR, 32'h00000002);
		rd(NORMAL_STATUS_ADDR, 32'h00000001);
		rd(FAST_STATUS_ADDR, 32'h00000002);
		wr(ENABLE_CLEAR_ADDR, 32'h00000001);
		repeat (3) @(posedge core_clk);
		#1 chk("normal", 32'(normal_irq), 32'h0);
		chk("enabled", enabled, 32'h00000002);
	endtask : t_route
	// Event flag is masked, then unmasked, then cleared by writing one.
	task automatic t_event();
		wr(EVENT_STATUS_ADDR, 32'hffffffff);
		want <= 32'h00000008;
		repeat (4) @(posedge core_clk);
		#1 chk("event irq", 32'(ev_irq), 32'h0);
		rd(EVENT_STATUS_ADDR, 32'h00000008);
		wr(EVENT_MASK_ADDR, 32'h00000008);
		repeat (2) @(posedge core_clk);
		#1 chk("event irq", 32'(ev_irq), 32'h1);
		wr(EVENT_STATUS_ADDR, 32'h00000008);
		repeat (2) @(posedge core_clk);
		#1 chk("event irq", 32'(ev_irq), 32'h0);
	endtask : t_event
	// Prints the counts and the verdict, then ends the run.
	task automatic tally_and_finish();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	// Cuts a hung run short.
	initial begin
		repeat (5000) @(posedge core_clk);
		errors++;
		tally_and_finish();
	end
	// Main sequence.
	initial begin
		repeat (5) @(posedge core_clk);
		arst_n <= 1'h1;
		t_reset();
		t_enable();
		t_forced();
		t_raw();
		t_route();
		t_event();
		tally_and_finish();
	end
endmodule : test_irq_input_stage
`default_nettype wire
